/* include/hdp_defines.svh */
// Constants of the host direct port: field positions, reset values and cycle counts.
`ifndef HDP_DEFINES_SVH
`define HDP_DEFINES_SVH

`define HDP_ADDR_MSB        13
`define HDP_MEM_TYPE_BIT    14
`define HDP_PAGE_SEL_BIT    15
`define HDP_DPAGE_MSB       7
`define HDP_DPAGE_LSB       4
`define HDP_PPAGE_MSB       3
`define HDP_PPAGE_LSB       0
`define HDP_PTR_RESET       16'h0000
`define HDP_PAGE_RESET      16'h0000
`define HDP_BUS_IDLE        16'hFFFF
`define HDP_ADDR_ONE        14'h0001
`define HDP_LATCH_CYCLES    4'h4
`define HDP_SHORT_CYCLES    4'h6
`define HDP_GAP_CYCLES      4'h4

`endif

/* include/hdp_pkg.sv */
// Types shared by both ends of the host direct port.
package hdp_pkg;

  typedef enum logic [2:0] {
    HDP_IDLE,
    HDP_WAIT_BND,
    HDP_ISSUE,
    HDP_CAPT,
    HDP_SECOND,
    HDP_RELEASE
  } hdp_dev_state_t;

  typedef enum logic [1:0] {
    HDP_H_IDLE,
    HDP_H_LATCH,
    HDP_H_READ,
    HDP_H_GAP
  } hdp_host_state_t;

endpackage : hdp_pkg

/* include/hdp_if.sv */
// Link between the host and the device end of the host direct port.
`timescale 1ns/1ps
`include "hdp_defines.svh"

interface hdp_if;
  logic        addr_latch_strobe;
  logic        port_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        access_ack_n;
  logic [15:0] ad_from_host;
  logic        ad_host_oe_n;
  logic [15:0] ad_from_dev;
  logic        ad_dev_oe_n;
  logic [15:0] host_ad_bus;

  // The shared bus floats high when neither end drives it.
  assign host_ad_bus = !ad_dev_oe_n  ? ad_from_dev :
                       !ad_host_oe_n ? ad_from_host : `HDP_BUS_IDLE;

  modport dev (
    input  addr_latch_strobe,
    input  port_select_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  host_ad_bus,
    output access_ack_n,
    output ad_from_dev,
    output ad_dev_oe_n
  );

  modport host (
    output addr_latch_strobe,
    output port_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output ad_from_host,
    output ad_host_oe_n,
    input  access_ack_n,
    input  host_ad_bus
  );
endinterface : hdp_if

/* design/hdp_device.sv */
// Device end of the host direct port: latch, long and short reads into core memory.
//
// Contract
// RULE_01: Acknowledge high means busy; start only when low.
// RULE_02: Latch cycle loads address and memory type.
// RULE_03: Latch with bit 15 set loads page fields.
// RULE_04: Host keeps read and write strobes high.
// RULE_05: Data memory pointer steps after each word.
// RULE_06: Program memory pointer steps after each pair.
// RULE_07: Address field wraps from top to zero.
// RULE_08: Core and host never write pointer together.
// RULE_09: Read raises acknowledge, drops it when data valid.
// RULE_10: Long read samples after acknowledge falls.
// RULE_11: Latch strobe low, write strobe high during reads.
// RULE_12: Each memory access steals one boundary cycle.
// RULE_13: First read answers after sync plus memory cycle.
// RULE_14: Second program half served from held word.
// RULE_15: Second half gives low byte, upper zero.
// RULE_16: Program words go upper sixteen bits first.
// RULE_17: New latch or core write drops second half.
// RULE_18: Short read captures on strobe rising edge.
// RULE_19: Short read host discards the first read.
// RULE_20: Short read returns the previously fetched word.
// RULE_21: Last fetched word is held as buffer.
// RULE_22: Host strobes pass a two-flop synchroniser.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "hdp_defines.svh"

module hdp_device (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Host link
  hdp_if.dev               link,
  // Core memory port
  input  wire logic        instr_boundary,
  output logic             mem_rd_q,
  output logic             mem_pm_q,
  output logic [13:0]      mem_addr_q,
  input  wire logic [23:0] mem_rdata,
  // Core access to the port registers
  input  wire logic        core_ptr_wr,
  input  wire logic [15:0] core_ptr_wdata,
  input  wire logic        core_page_wr,
  input  wire logic [15:0] core_page_wdata,
  output logic [15:0]      ptr_q,
  output logic [15:0]      page_q
);

  // Steps the address field and keeps the memory type bit.
  function automatic logic [15:0] hdp_step(input logic [15:0] p);
    hdp_step = {p[15:14], p[`HDP_ADDR_MSB:0] + `HDP_ADDR_ONE}; // RULE_07
  endfunction : hdp_step

  logic [3:0]  strb_s1_q;
  logic [3:0]  strb_s2_q;
  logic [15:0] bus_s1_q;
  logic [15:0] bus_s2_q;

  // Strobes and bus are synchronised before any logic reads them.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strb_s1_q <= 4'h7;
      strb_s2_q <= 4'h7;
      bus_s1_q  <= `HDP_BUS_IDLE;
      bus_s2_q  <= `HDP_BUS_IDLE;
    end else begin
      strb_s1_q <= {link.addr_latch_strobe, link.port_select_n,
                    link.read_strobe_n, link.write_strobe_n}; // RULE_22
      strb_s2_q <= strb_s1_q; // RULE_22
      bus_s1_q  <= link.host_ad_bus;
      bus_s2_q  <= bus_s1_q;
    end
  end

  logic latch_act;
  logic rd_act;

  // A latch needs read and write high; a read needs the latch strobe low.
  assign latch_act = strb_s2_q[3] && !strb_s2_q[2] && strb_s2_q[1] && strb_s2_q[0]; // RULE_04
  assign rd_act    = !strb_s2_q[3] && !strb_s2_q[2] && !strb_s2_q[1] && strb_s2_q[0]; // RULE_11

  hdp_pkg::hdp_dev_state_t state_q;
  hdp_pkg::hdp_dev_state_t state_d;
  logic [15:0] ptr_d;
  logic [15:0] page_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic [7:0]  low_q;
  logic [7:0]  low_d;
  logic        second_q;
  logic        second_d;
  logic        ack_n_q;
  logic        ack_n_d;
  logic        oe_n_q;
  logic        oe_n_d;
  logic        mem_rd_d;
  logic        mem_pm_d;
  logic [13:0] mem_addr_d;

  always_comb begin
    state_d    = state_q;
    ptr_d      = ptr_q;
    page_d     = page_q;
    out_d      = out_q;
    low_d      = low_q;
    second_d   = second_q;
    ack_n_d    = ack_n_q;
    oe_n_d     = oe_n_q;
    mem_rd_d   = 1'b0;
    mem_pm_d   = mem_pm_q;
    mem_addr_d = mem_addr_q;
    if (!rd_act) begin
      oe_n_d = 1'b1;
    end
    unique case (state_q)
      hdp_pkg::HDP_IDLE: begin
        if (latch_act) begin
          if (bus_s2_q[`HDP_PAGE_SEL_BIT]) begin
            page_d = {8'h00, bus_s2_q[`HDP_DPAGE_MSB:`HDP_DPAGE_LSB],
                      bus_s2_q[`HDP_PPAGE_MSB:`HDP_PPAGE_LSB]}; // RULE_03
          end else begin
            ptr_d    = {1'b0, bus_s2_q[`HDP_MEM_TYPE_BIT:0]}; // RULE_02
            second_d = 1'b0; // RULE_17
          end
        end else if (rd_act) begin
          ack_n_d = 1'b1; // RULE_09
          oe_n_d  = 1'b0; // RULE_20
          if (second_q) begin
            state_d = hdp_pkg::HDP_SECOND; // RULE_14
          end else begin
            state_d = hdp_pkg::HDP_WAIT_BND;
          end
        end
      end
      hdp_pkg::HDP_WAIT_BND: begin
        if (instr_boundary) begin
          mem_rd_d   = 1'b1; // RULE_12
          mem_pm_d   = ptr_q[`HDP_MEM_TYPE_BIT];
          mem_addr_d = ptr_q[`HDP_ADDR_MSB:0];
          state_d    = hdp_pkg::HDP_ISSUE;
        end
      end
      hdp_pkg::HDP_ISSUE: begin
        state_d = hdp_pkg::HDP_CAPT;
      end
      hdp_pkg::HDP_CAPT: begin
        if (mem_pm_q) begin
          out_d    = mem_rdata[23:8]; // RULE_16
          low_d    = mem_rdata[7:0]; // RULE_21
          second_d = 1'b1; // RULE_06
        end else begin
          out_d = mem_rdata[15:0]; // RULE_21
          ptr_d = hdp_step(ptr_q); // RULE_05
        end
        ack_n_d = 1'b0; // RULE_13
        state_d = hdp_pkg::HDP_RELEASE;
      end
      hdp_pkg::HDP_SECOND: begin
        out_d    = {8'h00, low_q}; // RULE_15
        second_d = 1'b0;
        ptr_d    = hdp_step(ptr_q); // RULE_06
        ack_n_d  = 1'b0; // RULE_14
        state_d  = hdp_pkg::HDP_RELEASE;
      end
      hdp_pkg::HDP_RELEASE: begin
        if (!rd_act) begin
          state_d = hdp_pkg::HDP_IDLE; // RULE_01
        end
      end
      default: begin
        state_d = hdp_pkg::HDP_IDLE;
      end
    endcase
    // Core writes land after host actions, so the core wins a clash.
    if (core_ptr_wr) begin
      ptr_d    = {1'b0, core_ptr_wdata[`HDP_MEM_TYPE_BIT:0]}; // RULE_08
      second_d = 1'b0; // RULE_17
    end
    if (core_page_wr) begin
      page_d = {8'h00, core_page_wdata[7:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q    <= hdp_pkg::HDP_IDLE;
      ptr_q      <= `HDP_PTR_RESET;
      page_q     <= `HDP_PAGE_RESET;
      out_q      <= 16'h0000;
      low_q      <= 8'h00;
      second_q   <= 1'b0;
      ack_n_q    <= 1'b0;
      oe_n_q     <= 1'b1;
      mem_rd_q   <= 1'b0;
      mem_pm_q   <= 1'b0;
      mem_addr_q <= 14'h0000;
    end else begin
      state_q    <= state_d;
      ptr_q      <= ptr_d;
      page_q     <= page_d;
      out_q      <= out_d;
      low_q      <= low_d;
      second_q   <= second_d;
      ack_n_q    <= ack_n_d;
      oe_n_q     <= oe_n_d;
      mem_rd_q   <= mem_rd_d;
      mem_pm_q   <= mem_pm_d;
      mem_addr_q <= mem_addr_d;
    end
  end

  // Link outputs come straight from registers.
  assign link.access_ack_n = ack_n_q;
  assign link.ad_from_dev  = out_q;
  assign link.ad_dev_oe_n  = oe_n_q;

endmodule : hdp_device

/* design/hdp_host.sv */
// Host end of the host direct port: issues latch cycles and long or short reads.
`timescale 1ns/1ps
`include "hdp_defines.svh"

module hdp_host (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Host link
  hdp_if.host              link,
  // User command port
  input  wire logic        cmd_latch,
  input  wire logic        cmd_read,
  input  wire logic        cmd_short,
  input  wire logic [15:0] cmd_wdata,
  output logic             busy_q,
  output logic [15:0]      rdata_q,
  output logic             rdata_valid_q
);

  logic        ack_s1_q;
  logic        ack_s2_q;
  logic [15:0] bus_s1_q;
  logic [15:0] bus_s2_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      bus_s1_q <= `HDP_BUS_IDLE;
      bus_s2_q <= `HDP_BUS_IDLE;
    end else begin
      ack_s1_q <= link.access_ack_n;
      ack_s2_q <= ack_s1_q;
      bus_s1_q <= link.host_ad_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  hdp_pkg::hdp_host_state_t state_q;
  hdp_pkg::hdp_host_state_t state_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        short_q;
  logic        short_d;
  logic        seen_q;
  logic        seen_d;
  logic        ale_q;
  logic        ale_d;
  logic        sel_n_q;
  logic        sel_n_d;
  logic        rd_n_q;
  logic        rd_n_d;
  logic        oe_n_q;
  logic        oe_n_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;
  logic        busy_d;
  logic [15:0] rdata_d;
  logic        rdata_valid_d;

  always_comb begin
    state_d       = state_q;
    cnt_d         = cnt_q;
    short_d       = short_q;
    seen_d        = seen_q;
    ale_d         = ale_q;
    sel_n_d       = sel_n_q;
    rd_n_d        = rd_n_q;
    oe_n_d        = oe_n_q;
    wdata_d       = wdata_q;
    rdata_d       = rdata_q;
    rdata_valid_d = 1'b0;
    unique case (state_q)
      hdp_pkg::HDP_H_IDLE: begin
        if (!ack_s2_q && cmd_latch) begin // RULE_01
          ale_d   = 1'b1; // RULE_04
          sel_n_d = 1'b0; // RULE_02
          oe_n_d  = 1'b0;
          wdata_d = cmd_wdata; // RULE_03
          cnt_d   = `HDP_LATCH_CYCLES;
          state_d = hdp_pkg::HDP_H_LATCH;
        end else if (!ack_s2_q && cmd_read) begin // RULE_01
          sel_n_d = 1'b0; // RULE_11
          rd_n_d  = 1'b0;
          short_d = cmd_short;
          seen_d  = 1'b0;
          cnt_d   = `HDP_SHORT_CYCLES;
          state_d = hdp_pkg::HDP_H_READ;
        end
      end
      hdp_pkg::HDP_H_LATCH: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          ale_d   = 1'b0;
          sel_n_d = 1'b1;
          oe_n_d  = 1'b1;
          cnt_d   = `HDP_GAP_CYCLES;
          state_d = hdp_pkg::HDP_H_GAP;
        end
      end
      hdp_pkg::HDP_H_READ: begin
        if (ack_s2_q) begin
          seen_d = 1'b1;
        end
        cnt_d = cnt_q - 4'h1;
        if ((short_q && cnt_q == 4'h1) || (!short_q && seen_q && !ack_s2_q)) begin
          rdata_d       = bus_s2_q; // RULE_10 RULE_18
          rdata_valid_d = 1'b1;
          sel_n_d       = 1'b1;
          rd_n_d        = 1'b1;
          cnt_d         = `HDP_GAP_CYCLES;
          state_d       = hdp_pkg::HDP_H_GAP;
        end
      end
      hdp_pkg::HDP_H_GAP: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          state_d = hdp_pkg::HDP_H_IDLE;
        end
      end
      default: begin
        state_d = hdp_pkg::HDP_H_IDLE;
      end
    endcase
    busy_d = (state_d != hdp_pkg::HDP_H_IDLE) || ack_s2_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q       <= hdp_pkg::HDP_H_IDLE;
      cnt_q         <= 4'h0;
      short_q       <= 1'b0;
      seen_q        <= 1'b0;
      ale_q         <= 1'b0;
      sel_n_q       <= 1'b1;
      rd_n_q        <= 1'b1;
      oe_n_q        <= 1'b1;
      wdata_q       <= 16'h0000;
      busy_q        <= 1'b1;
      rdata_q       <= 16'h0000;
      rdata_valid_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      short_q       <= short_d;
      seen_q        <= seen_d;
      ale_q         <= ale_d;
      sel_n_q       <= sel_n_d;
      rd_n_q        <= rd_n_d;
      oe_n_q        <= oe_n_d;
      wdata_q       <= wdata_d;
      busy_q        <= busy_d;
      rdata_q       <= rdata_d;
      rdata_valid_q <= rdata_valid_d;
    end
  end

  // Writes are not issued by this end, so the write strobe stays high.
  assign link.addr_latch_strobe = ale_q;
  assign link.port_select_n     = sel_n_q;
  assign link.read_strobe_n     = rd_n_q;
  assign link.write_strobe_n    = 1'b1;
  assign link.ad_from_host      = wdata_q;
  assign link.ad_host_oe_n      = oe_n_q;

endmodule : hdp_host

/* sim/hdp_link_properties.sv */
// Concurrent checks on the link signals of the host direct port.
`timescale 1ns/1ps

module hdp_link_properties (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Link signals
  input wire logic        addr_latch_strobe,
  input wire logic        port_select_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic        access_ack_n,
  input wire logic [15:0] ad_from_dev,
  input wire logic        ad_dev_oe_n,
  input wire logic        ad_host_oe_n
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_read_start;
    $fell(read_strobe_n) && !port_select_n;
  endsequence
  sequence s_fetch;
    !access_ack_n [*2] ##[1:2] access_ack_n;
  endsequence

  property p_latch_strobes;
    addr_latch_strobe |-> read_strobe_n && write_strobe_n;
  endproperty
  property p_read_strobes;
    !read_strobe_n |-> !addr_latch_strobe && write_strobe_n;
  endproperty
  property p_start_idle;
    $rose(addr_latch_strobe) || $fell(read_strobe_n) |-> !access_ack_n;
  endproperty
  property p_fetch;
    s_read_start |-> s_fetch;
  endproperty
  property p_ack_bounded;
    $rose(access_ack_n) |-> ##[1:40] !access_ack_n;
  endproperty
  property p_dev_drives;
    $fell(access_ack_n) && !read_strobe_n |-> !ad_dev_oe_n;
  endproperty
  property p_hold_word;
    !access_ack_n && !$past(access_ack_n) && !ad_dev_oe_n && !$past(ad_dev_oe_n)
      |-> $stable(ad_from_dev);
  endproperty
  property p_latch_bus;
    addr_latch_strobe && !port_select_n |-> !ad_host_oe_n && ad_dev_oe_n;
  endproperty

  a_latch_strobes: assert property (p_latch_strobes)
    else $error("Strobe active in latch.");
  a_read_strobes: assert property (p_read_strobes)
    else $error("Latch or write during read.");
  a_start_idle: assert property (p_start_idle)
    else $error("Cycle started while busy.");
  a_fetch: assert property (p_fetch)
    else $error("Acknowledge rise timing wrong.");
  a_ack_bounded: assert property (p_ack_bounded)
    else $error("Acknowledge stuck high.");
  a_dev_drives: assert property (p_dev_drives)
    else $error("Ready without bus drive.");
  a_hold_word: assert property (p_hold_word)
    else $error("Held word changed.");
  a_latch_bus: assert property (p_latch_bus)
    else $error("Bus drive wrong in latch.");
endmodule : hdp_link_properties

/* sim/host_memory_port_latch_read_test.sv */
// Self-checking bench joining the host and device ends of the host direct port.
`timescale 1ns/1ps

`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) begin \
      bad_count++; \
      $display("Error %0t: got %h exp %h", $time, a, e); \
    end \
  end

module host_memory_port_latch_read_test;
  logic        sys_clk;
  logic        reset_n;
  logic        instr_boundary;
  logic        mem_rd_q;
  logic        mem_pm_q;
  logic [13:0] mem_addr_q;
  logic [23:0] mem_rdata;
  logic        core_ptr_wr;
  logic [15:0] core_ptr_wdata;
  logic        core_page_wr;
  logic [15:0] core_page_wdata;
  logic [15:0] ptr_q;
  logic [15:0] page_q;
  logic        cmd_latch;
  logic        cmd_read;
  logic        cmd_short;
  logic [15:0] cmd_wdata;
  logic        busy_q;
  logic [15:0] rdata_q;
  logic        rdata_valid_q;
  logic [15:0] r;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  hdp_if link ();

  hdp_device u_hdp_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .instr_boundary(instr_boundary), .mem_rd_q(mem_rd_q), .mem_pm_q(mem_pm_q),
    .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .core_ptr_wr(core_ptr_wr),
    .core_ptr_wdata(core_ptr_wdata), .core_page_wr(core_page_wr),
    .core_page_wdata(core_page_wdata),
    .ptr_q(ptr_q), .page_q(page_q));

  hdp_host u_hdp_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .cmd_latch(cmd_latch), .cmd_read(cmd_read), .cmd_short(cmd_short),
    .cmd_wdata(cmd_wdata), .busy_q(busy_q), .rdata_q(rdata_q),
    .rdata_valid_q(rdata_valid_q));

  hdp_link_properties u_hdp_link_properties (.sys_clk(sys_clk), .reset_n(reset_n),
    .addr_latch_strobe(link.addr_latch_strobe), .port_select_n(link.port_select_n),
    .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
    .access_ack_n(link.access_ack_n), .ad_from_dev(link.ad_from_dev),
    .ad_dev_oe_n(link.ad_dev_oe_n), .ad_host_oe_n(link.ad_host_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Core memory answers the cycle after a request and churns otherwise.
  always @(posedge sys_clk) begin
    cyc++;
    if (mem_rd_q) begin
      mem_rdata <= {~mem_addr_q[7:0], mem_pm_q, 1'b1, mem_addr_q};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task results();
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task op(input logic lat, input logic rdc, input logic sh, input logic [15:0] w);
    int i;
    i = 0;
    while (busy_q !== 1'b0 && i < 200) begin
      @(negedge sys_clk);
      i++;
    end
    @(posedge sys_clk);
    cmd_latch <= lat;
    cmd_read  <= rdc;
    cmd_short <= sh;
    cmd_wdata <= w;
    @(posedge sys_clk);
    cmd_latch <= 1'b0;
    cmd_read  <= 1'b0;
    r = 16'hXXXX;
    for (i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      if (rdata_valid_q === 1'b1) r = rdata_q;
      if (busy_q === 1'b0 && i > 2) break;
    end
  endtask : op

  task t_dm_wrap();
    op(1'b1, 1'b0, 1'b0, 16'h3FFE);
    `CHK(ptr_q, 16'h3FFE);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'h7FFE);
    `CHK(ptr_q, 16'h3FFF);
    @(posedge sys_clk);
    instr_boundary <= 1'b0;
    fork
      op(1'b0, 1'b1, 1'b0, 16'h0000);
      begin
        repeat (12) @(posedge sys_clk);
        `CHK(ptr_q, 16'h3FFF);
        `CHK(link.read_strobe_n, 1'b0);
        instr_boundary <= 1'b1;
      end
    join
    `CHK(r, 16'h7FFF);
    `CHK(ptr_q, 16'h0000);
  endtask : t_dm_wrap

  task t_page();
    op(1'b1, 1'b0, 1'b0, 16'hF3A5);
    `CHK(page_q, 16'h00A5);
    `CHK(ptr_q, 16'h0000);
    @(posedge sys_clk);
    core_page_wr    <= 1'b1;
    core_page_wdata <= 16'h12C7;
    @(posedge sys_clk);
    core_page_wr    <= 1'b0;
    @(negedge sys_clk);
    `CHK(page_q, 16'h00C7);
  endtask : t_page

  task t_pm();
    op(1'b1, 1'b0, 1'b0, 16'h4005);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'hFAC0);
    `CHK(ptr_q, 16'h4005);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'h0005);
    `CHK(ptr_q, 16'h4006);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'hF9C0);
    op(1'b1, 1'b0, 1'b0, 16'h4020);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'hDFC0);
    @(posedge sys_clk);
    core_ptr_wr    <= 1'b1;
    core_ptr_wdata <= 16'h0030;
    @(posedge sys_clk);
    core_ptr_wr    <= 1'b0;
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    `CHK(r, 16'h4030);
    `CHK(ptr_q, 16'h0031);
  endtask : t_pm

  task t_short();
    op(1'b1, 1'b0, 1'b0, 16'h0040);
    op(1'b0, 1'b1, 1'b1, 16'h0000);
    `CHK(r, 16'h4030);
    op(1'b0, 1'b1, 1'b1, 16'h0000);
    `CHK(r, 16'h4040);
    @(posedge sys_clk);
    instr_boundary <= 1'b0;
    fork
      op(1'b0, 1'b1, 1'b1, 16'h0000);
      begin
        repeat (14) @(posedge sys_clk);
        `CHK(r, 16'h4041);
        instr_boundary <= 1'b1;
      end
    join
    `CHK(r, 16'h4041);
    `CHK(ptr_q, 16'h0043);
  endtask : t_short

  initial begin
    reset_n        = 1'b0;
    instr_boundary = 1'b1;
    cmd_latch      = 1'b0;
    cmd_read       = 1'b0;
    cmd_short      = 1'b0;
    cmd_wdata      = 16'h0000;
    core_ptr_wr    = 1'b0;
    core_ptr_wdata = 16'h0000;
    core_page_wr    = 1'b0;
    core_page_wdata = 16'h0000;
    mem_rdata      = 24'h000000;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    `CHK(page_q, 16'h0000);
    t_dm_wrap();
    t_page();
    t_pm();
    t_short();
    results();
  end
endmodule : host_memory_port_latch_read_test
